// ===== logic/ixp_defs.svh
// constants shared by the io expander design files
`ifndef IXP_DEFS_SVH
`define IXP_DEFS_SVH

// ==============================================================
// timing
`define IXP_CLK_NS      5
`define IXP_SPIKE_NS    10
`define IXP_SPIKE_CYC   ((`IXP_SPIKE_NS + `IXP_CLK_NS - 1) / `IXP_CLK_NS)
`define IXP_PIN_FILT    2
`define IXP_INIT_CYC    2'h3

// ==============================================================
// serial bus framing
`define IXP_ADDR_HI     4'h4
`define IXP_BYTE_BITS   4'h8

// ==============================================================
// register pairs, selected by pointer bits 2:1
`define IXP_PAIR_IN     2'h0
`define IXP_PAIR_OUT    2'h1
`define IXP_PAIR_POL    2'h2
`define IXP_PAIR_CFG    2'h3

// ==============================================================
// reset values
`define IXP_OUT_RST     8'hff
`define IXP_POL_RST     8'h00
`define IXP_CFG_RST     8'hff

// ==============================================================
// wishbone byte offsets
`define IXP_WB_STS      4'h0
`define IXP_WB_MASK     4'h4
`define IXP_WB_LIVE     4'h8

`endif

// ===== logic/ixp_pkg.sv
// types shared by the io expander design files
package ixp_pkg;

	// gray along idle, addr, ack, write, ack, read, ack
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_ACK_A = 3'h3,
		ST_WR    = 3'h2,
		ST_ACK_W = 3'h6,
		ST_RD    = 3'h7,
		ST_ACK_R = 3'h5
	} ixp_state_t;

	typedef logic [1:0][7:0] ixp_banks_t;

	typedef struct packed {
		logic change;
		logic write;
	} ixp_ev_t;

	typedef struct packed {
		ixp_state_t state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic       rw;
		logic       cmd;
		logic       nack;
		logic [2:0] ptr;
		ixp_banks_t in_q;
		ixp_banks_t out_q;
		ixp_banks_t pol_q;
		ixp_banks_t cfg_q;
		logic [1:0] init;
		logic       scl_q;
		logic       sda_q;
		logic       sda_oe_b;
		logic       alert_oe_b;
		logic       mism_q;
		logic       low_q;
		ixp_ev_t    ev;
	} ixp_top_st_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [1:0]  sts;
		logic [1:0]  mask;
		logic        irq;
	} ixp_wb_st_t;

endpackage

// ===== logic/ixp_sync.sv
// two-flop synchroniser with a majority-free stability filter per bit
`timescale 1ns/10ps
`include "ixp_defs.svh"

module ixp_sync
	import ixp_pkg::*;
#(
	parameter int         W    = 1,
	parameter int         FILT = 2,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	// raw and filtered levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0]           m;
		logic [W-1:0]           s2;
		logic [W-1:0][FILT-1:0] h;
		logic [W-1:0]           q;
	} ixp_sync_st_t;

	ixp_sync_st_t s_r;
	ixp_sync_st_t s_nxt;
	logic [W-1:0] all_hi;
	logic [W-1:0] all_lo;

	// ==============================================================
	// per-bit agreement of the sample history
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			assign all_hi[gi] = &s_r.h[gi];
			assign all_lo[gi] = ~|s_r.h[gi];
		end
	endgenerate

	// ==============================================================
	// next state
	always_comb begin
		s_nxt    = s_r;
		s_nxt.m  = d;
		s_nxt.s2 = s_r.m;
		for (int i = 0; i < W; i++) begin
			s_nxt.h[i] = {s_r.h[i][FILT-2:0], s_r.s2[i]};
		end
		// level moves only after FILT equal samples
		s_nxt.q = (s_r.q | all_hi) & ~all_lo;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			// keep sampling so the history is real at release
			s_r   <= s_nxt;
			s_r.q <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule

// ===== logic/ixp_wb_irq.sv
// wishbone slave holding sticky event status, mask and live mismatch
`timescale 1ns/10ps
`include "ixp_defs.svh"

module ixp_wb_irq
	import ixp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// events and state from the expander core
	input  ixp_ev_t          ev,
	input  wire logic [15:0] live,
	// wishbone classic slave
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// interrupt
	output logic             irq_o
);
	ixp_wb_st_t s_r;
	ixp_wb_st_t s_nxt;

	always_comb begin
		logic       hit;
		logic       wr;
		logic [1:0] clr;
		hit       = wb_cyc_i & wb_stb_i & ~s_r.ack;
		wr        = hit & wb_we_i & wb_sel_i[0];
		clr       = 2'h0;
		s_nxt     = s_r;
		s_nxt.ack = hit;
		s_nxt.dat = 32'h0;
		if (hit) begin
			unique case (wb_adr_i)
				`IXP_WB_STS: begin
					s_nxt.dat = {30'h0, s_r.sts};
					if (wr) begin
						clr = wb_dat_i[1:0];
					end
				end
				`IXP_WB_MASK: begin
					s_nxt.dat = {30'h0, s_r.mask};
					if (wr) begin
						s_nxt.mask = wb_dat_i[1:0];
					end
				end
				`IXP_WB_LIVE: begin
					s_nxt.dat = {16'h0, live};
				end
				// unmapped: acked, reads zero, writes dropped
				default: begin
					s_nxt.dat = 32'h0;
				end
			endcase
		end
		// a new event beats a clear in the same cycle
		s_nxt.sts = (s_r.sts & ~clr) | ev;
		s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign irq_o    = s_r.irq;
endmodule

// ===== logic/ixp_top.sv
// sixteen-pin serial-bus io expander with change alert
// ==============================================================
// Function
// - two 8-bit registers of each kind
// - written direction bits steer the pins
// - input and output registers hold pin values
// - polarity bits invert input data on read
// - every register readable over serial bus
// - alert while a pin differs from input register
// - alert is open-drain and active low
// - reset loads defaults, bus machine goes idle
// - three straps form low slave address bits
// - all sixteen pins are inputs after reset
// - serial clock works from static to 400 kHz
// - glitches on clock and data are filtered
// - first write byte selects one of eight registers
// - pointer alternates within pair after each byte
// - direction 1 input, 0 output; given defaults
// - input writes ignored; output reads stored value
//
// Our own choices: the placing of the registers and event status and interrupt over Wishbone.
`timescale 1ns/10ps
`include "ixp_defs.svh"

module ixp_top
	import ixp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// serial bus, open drain
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_b,
	// change alert, open drain
	output logic             alert_o,
	output logic             alert_oe_b,
	// address straps
	input  wire logic        strap_addr_bit_low,
	input  wire logic        strap_addr_bit_mid,
	input  wire logic        strap_addr_bit_high,
	// port pins
	input  wire logic [7:0]  bank_zero_pins_i,
	output logic      [7:0]  bank_zero_pins_o,
	output logic      [7:0]  bank_zero_pins_oe_b,
	input  wire logic [7:0]  bank_one_pins_i,
	output logic      [7:0]  bank_one_pins_o,
	output logic      [7:0]  bank_one_pins_oe_b,
	// wishbone classic slave
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// interrupt
	output logic             irq_o
);

	localparam ixp_top_st_t TOP_RST = '{
		state:      ST_IDLE,
		cnt:        4'h0,
		shift:      8'h00,
		rw:         1'b0,
		cmd:        1'b0,
		nack:       1'b0,
		ptr:        3'h0,
		in_q:       '0,
		out_q:      {`IXP_OUT_RST, `IXP_OUT_RST},
		pol_q:      {`IXP_POL_RST, `IXP_POL_RST},
		cfg_q:      {`IXP_CFG_RST, `IXP_CFG_RST},
		init:       `IXP_INIT_CYC,
		scl_q:      1'b1,
		sda_q:      1'b1,
		sda_oe_b:   1'b1,
		alert_oe_b: 1'b1,
		mism_q:     1'b0,
		low_q:      1'b0,
		ev:         '0
	};

	ixp_top_st_t s_r;
	ixp_top_st_t s_nxt;

	logic [1:0]  bus_f;
	logic [18:0] pins_raw;
	logic [18:0] pins_f;
	ixp_banks_t  pins_s;
	logic [6:0]  my_addr;
	logic        scl_f;
	logic        sda_f;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic [15:0] mism;

	// ==============================================================
	// input synchronisers
	// short spike filter: a 40 ns link clock phase must still pass
	ixp_sync #(
		.W    (2),
		.FILT (`IXP_SPIKE_CYC),
		.RST  (2'h3)
	) u_bus_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       ({scl_i, sda_i}),
		.q       (bus_f)
	);

	assign pins_raw = {strap_addr_bit_high, strap_addr_bit_mid,
		strap_addr_bit_low, bank_one_pins_i, bank_zero_pins_i};

	ixp_sync #(
		.W    (19),
		.FILT (`IXP_PIN_FILT),
		.RST  (19'h0)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       (pins_raw),
		.q       (pins_f)
	);

	assign scl_f    = bus_f[1];
	assign sda_f    = bus_f[0];
	assign pins_s   = pins_f[15:0];
	assign my_addr  = {`IXP_ADDR_HI, pins_f[18:16]};
	assign scl_rise = scl_f & ~s_r.scl_q;
	assign scl_fall = ~scl_f & s_r.scl_q;
	assign start_c  = scl_f & s_r.scl_q & s_r.sda_q & ~sda_f;
	assign stop_c   = scl_f & s_r.scl_q & ~s_r.sda_q & sda_f;
	assign mism     = pins_s ^ s_r.in_q;

	// ==============================================================
	// register read mux
	function automatic logic [7:0] rd_val(input logic [2:0] p);
		logic [7:0] v;
		v = 8'h00;
		unique case (p[2:1])
			`IXP_PAIR_IN:  v = pins_s[p[0]] ^ s_r.pol_q[p[0]];
			`IXP_PAIR_OUT: v = s_r.out_q[p[0]];
			`IXP_PAIR_POL: v = s_r.pol_q[p[0]];
			`IXP_PAIR_CFG: v = s_r.cfg_q[p[0]];
		endcase
		return v;
	endfunction

	// ==============================================================
	// next state
	always_comb begin
		logic [7:0] byte_v;
		logic [2:0] p_v;
		byte_v      = 8'h00;
		p_v         = s_r.ptr;
		s_nxt       = s_r;
		s_nxt.ev    = '0;
		s_nxt.low_q = 1'b0;
		s_nxt.scl_q = scl_f;
		s_nxt.sda_q = sda_f;

		// latch pin levels once synchronisers hold real values
		if (s_r.init != 2'h0) begin
			s_nxt.in_q = pins_s;
			s_nxt.init = s_r.init - 2'h1;
		end

		// repeated start is legal from any state
		if (start_c) begin
			s_nxt.state    = ST_ADDR;
			s_nxt.cnt      = 4'h0;
			s_nxt.sda_oe_b = 1'b1;
		end else if (stop_c) begin
			s_nxt.state    = ST_IDLE;
			s_nxt.sda_oe_b = 1'b1;
		end else begin
			unique case (s_r.state)
				ST_IDLE: begin
					s_nxt.sda_oe_b = 1'b1;
				end
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						s_nxt.shift = {s_r.shift[6:0], sda_f};
						s_nxt.cnt   = s_r.cnt + 4'h1;
					end else if (scl_fall
						&& s_r.cnt == `IXP_BYTE_BITS) begin
						s_nxt.cnt = 4'h0;
						if (s_r.state == ST_ADDR) begin
							if (s_r.shift[7:1] == my_addr) begin
								s_nxt.rw       = s_r.shift[0];
								s_nxt.cmd      = 1'b1;
								s_nxt.sda_oe_b = 1'b0;
								s_nxt.state    = ST_ACK_A;
							end else begin
								// another device's address
								s_nxt.state = ST_IDLE;
							end
						end else begin
							s_nxt.sda_oe_b = 1'b0;
							s_nxt.state    = ST_ACK_W;
							s_nxt.cmd      = 1'b0;
							if (s_r.cmd) begin
								s_nxt.ptr = s_r.shift[2:0];
							end else begin
								unique case (s_r.ptr[2:1])
									`IXP_PAIR_IN: begin
										// input pair is read only
										s_nxt.ev.write = 1'b0;
									end
									`IXP_PAIR_OUT: begin
										s_nxt.out_q[s_r.ptr[0]] =
											s_r.shift;
										s_nxt.ev.write = 1'b1;
									end
									`IXP_PAIR_POL: begin
										s_nxt.pol_q[s_r.ptr[0]] =
											s_r.shift;
										s_nxt.ev.write = 1'b1;
									end
									`IXP_PAIR_CFG: begin
										s_nxt.cfg_q[s_r.ptr[0]] =
											s_r.shift;
										s_nxt.ev.write = 1'b1;
									end
								endcase
								s_nxt.ptr = {s_r.ptr[2:1],
									~s_r.ptr[0]};
							end
						end
					end
				end
				ST_ACK_A: begin
					if (scl_fall) begin
						if (s_r.rw) begin
							byte_v         = rd_val(s_r.ptr);
							s_nxt.shift    = byte_v;
							s_nxt.sda_oe_b = byte_v[7];
							s_nxt.cnt      = 4'h0;
							s_nxt.state    = ST_RD;
							if (s_r.ptr[2:1] == `IXP_PAIR_IN) begin
								s_nxt.in_q[s_r.ptr[0]] =
									pins_s[s_r.ptr[0]];
							end
						end else begin
							s_nxt.sda_oe_b = 1'b1;
							s_nxt.state    = ST_WR;
						end
					end
				end
				ST_ACK_W: begin
					if (scl_fall) begin
						s_nxt.sda_oe_b = 1'b1;
						s_nxt.state    = ST_WR;
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_r.cnt == `IXP_BYTE_BITS) begin
							// release for the master's ack bit
							s_nxt.sda_oe_b = 1'b1;
							s_nxt.cnt      = 4'h0;
							s_nxt.state    = ST_ACK_R;
						end else begin
							s_nxt.shift    = {s_r.shift[6:0], 1'b0};
							s_nxt.sda_oe_b = s_r.shift[6];
						end
					end
				end
				ST_ACK_R: begin
					if (scl_rise) begin
						s_nxt.nack = sda_f;
					end else if (scl_fall) begin
						if (s_r.nack) begin
							s_nxt.state = ST_IDLE;
						end else begin
							p_v            = {s_r.ptr[2:1], ~s_r.ptr[0]};
							byte_v         = rd_val(p_v);
							s_nxt.ptr      = p_v;
							s_nxt.shift    = byte_v;
							s_nxt.sda_oe_b = byte_v[7];
							s_nxt.state    = ST_RD;
							if (p_v[2:1] == `IXP_PAIR_IN) begin
								s_nxt.in_q[p_v[0]] = pins_s[p_v[0]];
							end
						end
					end
				end
				default: begin
					s_nxt.state    = ST_IDLE;
					s_nxt.sda_oe_b = 1'b1;
				end
			endcase
		end

		// alert follows mismatch; quiet until the input latch is primed
		s_nxt.mism_q     = (|mism) & (s_r.init == 2'h0);
		s_nxt.alert_oe_b = ~s_nxt.mism_q;
		s_nxt.ev.change  = s_nxt.mism_q & ~s_r.mism_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_r <= TOP_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==============================================================
	// event status and interrupt over wishbone
	ixp_wb_irq u_wb_irq (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.ev       (s_r.ev),
		.live     (mism),
		.wb_adr_i (wb_adr_i),
		.wb_dat_i (wb_dat_i),
		.wb_sel_i (wb_sel_i),
		.wb_we_i  (wb_we_i),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.irq_o    (irq_o)
	);

	// ==============================================================
	// pins, all from flops; open-drain lines only ever pull low
	assign sda_o               = s_r.low_q;
	assign sda_oe_b            = s_r.sda_oe_b;
	assign alert_o             = s_r.low_q;
	assign alert_oe_b          = s_r.alert_oe_b;
	assign bank_zero_pins_o    = s_r.out_q[0];
	assign bank_zero_pins_oe_b = s_r.cfg_q[0];
	assign bank_one_pins_o     = s_r.out_q[1];
	assign bank_one_pins_oe_b  = s_r.cfg_q[1];
endmodule

// ===== sim/ixp_checker.sv
// port-level checks for the io expander top
`timescale 1ns/10ps

// ==============================================================
// checker
module ixp_checker (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// serial and alert lines
	input wire logic        scl_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_b,
	input wire logic        alert_o,
	input wire logic        alert_oe_b,
	// port pins
	input wire logic [7:0]  bank_zero_pins_o,
	input wire logic [7:0]  bank_zero_pins_oe_b,
	input wire logic [7:0]  bank_one_pins_o,
	input wire logic [7:0]  bank_one_pins_oe_b,
	// wishbone and interrupt
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("request not answered next cycle");
	a_wb_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_od_low_only: assert property (!sda_o && !alert_o)
		else $error("open drain line driven high");
	a_reset_pins: assert property (disable iff (1'b0) !rst_b |=>
		{bank_one_pins_oe_b, bank_zero_pins_oe_b} == 16'hffff &&
		{bank_one_pins_o, bank_zero_pins_o} == 16'hffff)
		else $error("pins not at defaults after reset");
	a_reset_idle: assert property (disable iff (1'b0) !rst_b |=>
		sda_oe_b && alert_oe_b && !irq_o && !wb_ack_o)
		else $error("outputs not idle after reset");
	a_alert_quiet: assert property ($rose(rst_b) |-> alert_oe_b [*3])
		else $error("alert during input priming");
	a_sda_scl_low: assert property ($changed(sda_oe_b) |-> !scl_i)
		else $error("data line moved while clock high");
	a_pins_scl_low: assert property ($changed({bank_one_pins_o,
		bank_zero_pins_o, bank_one_pins_oe_b, bank_zero_pins_oe_b})
		|-> !scl_i)
		else $error("pin register moved while clock high");
endmodule

bind ixp_top ixp_checker chk_i (.sys_clk, .rst_b, .scl_i, .sda_o, .sda_oe_b,
	.alert_o, .alert_oe_b, .bank_zero_pins_o, .bank_zero_pins_oe_b,
	.bank_one_pins_o, .bank_one_pins_oe_b, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .irq_o);

// ===== sim/ixp_i2c_master.sv
// serial bus master model driving the expander's clock and data
`timescale 1ns/10ps

// ==============================================================
// master
module ixp_i2c_master (
	// clock
	input wire logic  sys_clk,
	// serial bus, open drain: release high means not pulling
	output logic      scl,
	output logic      sda_rel,
	input wire logic  sda_in
);
	// 40 ns per phase, 80 ns period; clock stands high between frames
	localparam int HALF = 8;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// data moves mid-low so the filtered edges never coincide
	task bit_io(input logic b, output logic r);
		step(HALF / 2);
		sda_rel <= b;
		step(HALF / 2);
		scl <= 1'b1;
		step(HALF);
		r = sda_in;
		scl <= 1'b0;
	endtask
	task start;
		step(HALF / 2);
		sda_rel <= 1'b1;
		step(HALF / 2);
		scl <= 1'b1;
		step(HALF);
		sda_rel <= 1'b0;
		step(HALF);
		scl <= 1'b0;
	endtask
	task stop;
		step(HALF / 2);
		sda_rel <= 1'b0;
		step(HALF / 2);
		scl <= 1'b1;
		step(HALF);
		sda_rel <= 1'b1;
		step(HALF);
	endtask
	task wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// ===== sim/ixp_top_test.sv
// self-checking bench for the io expander
`timescale 1ns/10ps
`include "ixp_defs.svh"

module ixp_top_test;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        scl, sda_rel, sda_w, ack;
	logic [2:0]  strap = 3'h5;
	logic [7:0]  ext0 = 8'h00;
	logic [7:0]  ext1 = 8'h00;
	logic [7:0]  p0_o, p0_oe_b, p1_o, p1_oe_b, p0_i, p1_i;
	logic        sda_o, sda_oe_b, alert_o, alert_oe_b, wb_ack_o, irq_o;
	logic [31:0] wb_dat_o, rd;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic        wb_we_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [15:0] d16;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cycles = 0;

	always #2.5 sys_clk = ~sys_clk;
	// pulled-up wires: output pins follow the device, inputs the bench
	assign sda_w = sda_rel & (sda_oe_b | sda_o);
	assign p0_i = (ext0 & p0_oe_b) | (p0_o & ~p0_oe_b);
	assign p1_i = (ext1 & p1_oe_b) | (p1_o & ~p1_oe_b);

	ixp_i2c_master m (.sys_clk(sys_clk), .scl(scl), .sda_rel(sda_rel),
		.sda_in(sda_w));
	ixp_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
		.alert_o(alert_o), .alert_oe_b(alert_oe_b),
		.strap_addr_bit_low(strap[0]), .strap_addr_bit_mid(strap[1]),
		.strap_addr_bit_high(strap[2]), .bank_zero_pins_i(p0_i),
		.bank_zero_pins_o(p0_o), .bank_zero_pins_oe_b(p0_oe_b),
		.bank_one_pins_i(p1_i), .bank_one_pins_o(p1_o),
		.bank_one_pins_oe_b(p1_oe_b), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .irq_o(irq_o));

	// ==============================================================
	// tasks
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i <= we;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) @(posedge sys_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	task i2c_wr(input logic [2:0] s, input logic [7:0] p, a, b);
		logic k0, k1, k2, k3;
		m.start();
		m.wr_byte({`IXP_ADDR_HI, s, 1'b0}, k0);
		m.wr_byte(p, k1);
		m.wr_byte(a, k2);
		m.wr_byte(b, k3);
		m.stop();
		ack = k0 & k1 & k2 & k3;
	endtask
	task i2c_rd(input logic [7:0] p, output logic [15:0] d);
		logic k;
		m.start();
		m.wr_byte({`IXP_ADDR_HI, strap, 1'b0}, k);
		m.wr_byte(p, k);
		m.start();
		m.wr_byte({`IXP_ADDR_HI, strap, 1'b1}, k);
		m.rd_byte(1'b0, d[15:8]);
		m.rd_byte(1'b1, d[7:0]);
		m.stop();
	endtask

	// ==============================================================
	// hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ==============================================================
	// tests
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (20) @(posedge sys_clk);
		chk("dir", 16'hffff, {p1_oe_b, p0_oe_b});
		chk("out", 16'hffff, {p1_o, p0_o});
		$display("test reset done");
		i2c_wr(strap, 8'h06, 8'h0f, 8'hf0);
		chk("ack", 16'h1, {15'h0, ack});
		chk("dir", 16'hf00f, {p1_oe_b, p0_oe_b});
		i2c_wr(strap, 8'h03, 8'h3c, 8'h5a);
		chk("out", 16'h3c5a, {p1_o, p0_o});
		i2c_wr(strap ^ 3'h1, 8'h02, 8'h00, 8'h00);
		chk("nack", 16'h0, {15'h0, ack});
		chk("out", 16'h3c5a, {p1_o, p0_o});
		$display("test write done");
		ext0 <= 8'ha5;
		i2c_wr(strap, 8'h04, 8'hff, 8'h00);
		i2c_wr(strap, 8'h00, 8'h12, 8'h34);
		i2c_rd(8'h00, d16);
		chk("in", 16'haa0c, d16);
		i2c_rd(8'h02, d16);
		chk("out rd", 16'h5a3c, d16);
		i2c_rd(8'h04, d16);
		chk("pol rd", 16'hff00, d16);
		i2c_rd(8'h06, d16);
		chk("dir rd", 16'h0ff0, d16);
		$display("test read done");
		wb(1'b1, `IXP_WB_STS, 32'h3);
		// the change event sits in status bit 1
		wb(1'b1, `IXP_WB_MASK, 32'h2);
		wb(1'b0, `IXP_WB_STS, 32'h0);
		chk("status", 16'h0, rd[15:0]);
		chk("irq", 16'h0, {15'h0, irq_o});
		ext0 <= 8'ha0;
		repeat (20) @(posedge sys_clk);
		chk("alert", 16'h0, {15'h0, alert_oe_b});
		chk("irq", 16'h1, {15'h0, irq_o});
		wb(1'b0, `IXP_WB_LIVE, 32'h0);
		chk("live", 16'h0005, rd[15:0]);
		i2c_rd(8'h00, d16);
		chk("alert", 16'h1, {15'h0, alert_oe_b});
		wb(1'b1, `IXP_WB_STS, 32'h3);
		wb(1'b0, `IXP_WB_STS, 32'h0);
		chk("status", 16'h0, rd[15:0]);
		chk("irq", 16'h0, {15'h0, irq_o});
		ext0 <= 8'ha5;
		repeat (20) @(posedge sys_clk);
		chk("alert", 16'h0, {15'h0, alert_oe_b});
		ext0 <= 8'ha0;
		repeat (20) @(posedge sys_clk);
		chk("alert", 16'h1, {15'h0, alert_oe_b});
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", 16'h0, rd[15:0]);
		$display("test alert done");
		report_and_stop();
	end
endmodule
